// File: byte_dp_cfg.svh
`ifndef BYTE_DP_CFG_SVH
`define BYTE_DP_CFG_SVH
// Byte lane selector codes from index bits 23-22
`define SEL_HI 2'h1
`define SEL_MID 2'h2
`define SEL_LO 2'h3
`define SEL_NONE 2'h0
// Field positions
`define SEL_MSB 23
`define SEL_LSB 22
// Condition code encoding
`define CC_ZERO 3'h4
`define CC_NEG 3'h2
`define CC_POS 3'h1
`define CC_RESET 3'h4
`define ACC_RESET 24'h000000
`define NUM_GREGS 6
`endif

// File: byte_dp_pkg.sv
package byte_dp_pkg;
	typedef enum logic [3:0] {
		OP_NONE,
		extract_memory_byte,
		sign_extend_byte,
		zero_extend_byte,
		unsigned_compare_operand,
		negate_byte,
		or_operand_into_byte,
		absolute_byte,
		replace_memory_byte,
		query_byte_bits,
		subtract_operand_from_byte,
		store_low_byte,
		register_to_low_byte,
		load_operand_to_byte,
		load_memory_low_byte,
		xor_operand_with_byte
	} byte_op_t;
	typedef enum {ST_IDLE, ST_READ, ST_WRITE} dp_state_t;
endpackage

// File: byte_processing_datapath.sv
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "byte_dp_cfg.svh"
// How it works
// RULE1 - Extract word address is effective address plus extract index; bits 23-22 pick byte.
// RULE2 - Extract code 01 bits 23-16, 10 bits 15-8, 11 and 00 bits 7-0.
// RULE3 - Extract with final indexing adds named index before the extract index.
// RULE4 - Sign extend copies A7 into A23-A8; flags follow whole accumulator.
// RULE5 - Zero extend clears A23-A8; low byte and flags untouched.
// RULE6 - Unsigned compare of operand with low byte sets flags, changes no register.
// RULE7 - Negate low byte, keep upper bits, overflow on full-scale negative, byte flags.
// RULE8 - OR operand into low byte, keep upper bits, byte flags.
// RULE9 - Absolute value of low byte, overflow on full-scale negative, byte flags.
// RULE10 - Replace byte at address plus replace index; 01,10,11 select lanes, 00 nothing.
// RULE11 - Replace with final indexing ORs named index into replace index before add.
// RULE12 - Query ANDs operand with low byte, flags from result.
// RULE13 - Subtract signed operand from low byte, overflow on sign carry mismatch.
// RULE14 - Store byte overwrites memory bits 7-0, keeps 23-8.
// RULE15 - Register to byte copies low 8 bits into low byte, flags unchanged.
// RULE16 - Several selected source registers are ORed before the transfer.
// RULE17 - Load signed operand into low byte, keep upper bits, byte flags.
// RULE18 - Load memory bits 7-0 into low byte, keep upper bits, byte flags.
// RULE19 - XOR operand into low byte, keep upper bits, byte flags.
// RULE20 - Byte flags: negative if A7, zero if byte zero, else positive.
module byte_processing_datapath
	import byte_dp_pkg::*;
(
	// Clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic enable_in,
	// Instruction from sequencer
	input wire logic start_in,
	input wire byte_op_t op_in,
	input wire logic [7:0] operand_in,
	input wire logic [23:0] effective_address_in,
	input wire logic final_index_in,
	input wire logic [23:0] named_index_in,
	input wire logic [23:0] extract_index_in,
	input wire logic [23:0] replace_index_in,
	input wire logic [5:0] source_register_select_in,
	input wire logic [23:0] gregs_in [`NUM_GREGS],
	// Accumulator load from sequencer
	input wire logic acc_load_in,
	input wire logic [23:0] acc_data_in,
	// Memory port
	output logic mem_read_out,
	output logic mem_write_out,
	output logic [23:0] mem_addr_out,
	output logic [23:0] mem_wdata_out,
	input wire logic mem_ready_in,
	input wire logic [23:0] mem_rdata_in,
	// Results
	output logic [23:0] acc_out,
	output logic [2:0] cond_out,
	output logic overflow_out,
	output logic busy_out,
	output logic done_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [23:0] acc_reg;
	logic [2:0] cond_reg;
	logic overflow_reg;
	dp_state_t state_reg;
	byte_op_t op_reg;
	logic [1:0] sel_reg;
	logic [23:0] addr_reg;
	logic [23:0] wdata_reg;
	logic done_reg;

	// Flag code from the sign and value of one byte
	function automatic logic [2:0] flags8(input logic [7:0] b);
		if (b[7]) begin
			return `CC_NEG; // see RULE20
		end else if (b == 8'h00) begin
			return `CC_ZERO;
		end else begin
			return `CC_POS;
		end
	endfunction

	// ----------------------------------------
	// Combinational byte arithmetic
	// ----------------------------------------
	logic [7:0] b;
	logic [7:0] neg_b;
	logic [8:0] diff;
	logic sub_ovf;
	logic [23:0] src_or;
	logic [23:0] ext_addr;
	logic [23:0] rep_addr;
	logic [1:0] ext_sel;
	logic [1:0] rep_sel;

	assign b = acc_reg[7:0];
	assign neg_b = 8'(~b + 8'h01);
	assign diff = 9'({1'b0, b} - {1'b0, operand_in});
	// Carry into sign differs from carry out
	assign sub_ovf = (b[7] ^ operand_in[7]) & (diff[7] ^ b[7]); // see RULE13

	// ----------------------------------------
	// Source register merge
	// ----------------------------------------
	// Select bits are unitary, so any mix of registers may be asked for
	logic [23:0] src_chain [`NUM_GREGS + 1];
	assign src_chain[0] = 24'h000000;
	for (genvar g = 0; g < `NUM_GREGS; g++) begin : g_src
		assign src_chain[g + 1] = source_register_select_in[g] ?
			(src_chain[g] | gregs_in[g]) : src_chain[g]; // see RULE16
	end
	assign src_or = src_chain[`NUM_GREGS];

	// ----------------------------------------
	// Address formation for the indexed byte operations
	// ----------------------------------------
	always_comb begin
		if (final_index_in) begin
			ext_addr = effective_address_in + named_index_in + extract_index_in; // see RULE3
			rep_addr = effective_address_in + (named_index_in | replace_index_in); // see RULE11
		end else begin
			ext_addr = effective_address_in + extract_index_in; // see RULE1
			rep_addr = effective_address_in + replace_index_in; // see RULE10
		end
		ext_sel = extract_index_in[`SEL_MSB:`SEL_LSB];
		rep_sel = final_index_in ? (named_index_in[`SEL_MSB:`SEL_LSB] |
			replace_index_in[`SEL_MSB:`SEL_LSB]) : replace_index_in[`SEL_MSB:`SEL_LSB];
	end

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	logic go;
	// Requests that arrive while busy are dropped, not queued
	assign go = enable_in & start_in & (state_reg == ST_IDLE);

	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg <= ST_IDLE;
			op_reg <= OP_NONE;
			sel_reg <= 2'h0;
			addr_reg <= 24'h000000;
		end else if (enable_in) begin
			case (state_reg)
				ST_IDLE: begin
					if (go) begin
						op_reg <= op_in;
						case (op_in)
							extract_memory_byte: begin
								addr_reg <= ext_addr;
								sel_reg <= ext_sel;
								state_reg <= ST_READ;
							end
							replace_memory_byte: begin
								addr_reg <= rep_addr;
								sel_reg <= rep_sel;
								// Code 00 performs no memory access
								if (rep_sel != `SEL_NONE) begin
									state_reg <= ST_READ;
								end
							end
							store_low_byte, load_memory_low_byte: begin
								addr_reg <= effective_address_in;
								state_reg <= ST_READ;
							end
							default: begin
							end
						endcase
					end
				end
				ST_READ: begin
					if (mem_ready_in) begin
						// Byte stores read first so the other lanes survive the write
						if (op_reg == replace_memory_byte || op_reg == store_low_byte) begin
							state_reg <= ST_WRITE;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_WRITE: begin
					if (mem_ready_in) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Read-modify-write data for the byte stores
	// ----------------------------------------
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			wdata_reg <= 24'h000000;
		end else if (enable_in && state_reg == ST_READ && mem_ready_in) begin
			wdata_reg <= mem_rdata_in;
			if (op_reg == store_low_byte) begin
				wdata_reg[7:0] <= b; // see RULE14
			end else if (op_reg == replace_memory_byte) begin
				case (sel_reg)
					`SEL_HI: wdata_reg[23:16] <= b; // see RULE10
					`SEL_MID: wdata_reg[15:8] <= b;
					`SEL_LO: wdata_reg[7:0] <= b;
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Accumulator, condition and overflow
	// ----------------------------------------
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			acc_reg <= `ACC_RESET;
			cond_reg <= `CC_RESET;
			overflow_reg <= 1'b0;
		end else if (enable_in) begin
			// A load gives way to an operation taken in the same cycle
			if (acc_load_in && state_reg == ST_IDLE && !start_in) begin
				acc_reg <= acc_data_in;
			end else if (go) begin
				case (op_in)
					sign_extend_byte: begin
						acc_reg[23:8] <= {16{b[7]}}; // see RULE4
						cond_reg <= b[7] ? `CC_NEG : (b == 8'h00 ? `CC_ZERO : `CC_POS);
					end
					zero_extend_byte: acc_reg[23:8] <= 16'h0000; // see RULE5
					unsigned_compare_operand: begin
						// Flags only; accumulator is left alone
						if (b == operand_in) begin
							cond_reg <= `CC_ZERO; // see RULE6
						end else if (b < operand_in) begin
							cond_reg <= `CC_NEG;
						end else begin
							cond_reg <= `CC_POS;
						end
					end
					// Overflow is sticky; only reset clears it
					negate_byte: begin
						acc_reg[7:0] <= neg_b; // see RULE7
						cond_reg <= flags8(neg_b);
						overflow_reg <= overflow_reg | (b == 8'h80);
					end
					absolute_byte: begin
						acc_reg[7:0] <= b[7] ? neg_b : b; // see RULE9
						cond_reg <= flags8(b[7] ? neg_b : b);
						overflow_reg <= overflow_reg | (b == 8'h80);
					end
					or_operand_into_byte: begin
						acc_reg[7:0] <= b | operand_in; // see RULE8
						cond_reg <= flags8(b | operand_in);
					end
					query_byte_bits: cond_reg <= flags8(b & operand_in); // see RULE12
					subtract_operand_from_byte: begin
						acc_reg[7:0] <= diff[7:0]; // see RULE13
						cond_reg <= flags8(diff[7:0]);
						overflow_reg <= overflow_reg | sub_ovf;
					end
					register_to_low_byte: acc_reg[7:0] <= src_or[7:0]; // see RULE15
					load_operand_to_byte: begin
						acc_reg[7:0] <= operand_in; // see RULE17
						cond_reg <= flags8(operand_in);
					end
					xor_operand_with_byte: begin
						acc_reg[7:0] <= b ^ operand_in; // see RULE19
						cond_reg <= flags8(b ^ operand_in);
					end
					default: begin
					end
				endcase
			end else if (state_reg == ST_READ && mem_ready_in) begin
				if (op_reg == extract_memory_byte) begin
					case (sel_reg)
						`SEL_HI: begin
							acc_reg[7:0] <= mem_rdata_in[23:16]; // see RULE2
							cond_reg <= flags8(mem_rdata_in[23:16]);
						end
						`SEL_MID: begin
							acc_reg[7:0] <= mem_rdata_in[15:8];
							cond_reg <= flags8(mem_rdata_in[15:8]);
						end
						// Codes 11 and 00 both take the rightmost byte
						default: begin
							acc_reg[7:0] <= mem_rdata_in[7:0];
							cond_reg <= flags8(mem_rdata_in[7:0]);
						end
					endcase
				end else if (op_reg == load_memory_low_byte) begin
					acc_reg[7:0] <= mem_rdata_in[7:0]; // see RULE18
					cond_reg <= flags8(mem_rdata_in[7:0]);
				end
			end
		end
	end

	// ----------------------------------------
	// Completion
	// ----------------------------------------
	// Operations that finish without touching memory
	logic reg_only;
	logic last_access;
	always_comb begin
		case (op_in)
			extract_memory_byte, store_low_byte, load_memory_low_byte: reg_only = 1'b0;
			// Replace with code 00 is a no-op on memory and ends at once
			replace_memory_byte: reg_only = (rep_sel == `SEL_NONE);
			default: reg_only = 1'b1;
		endcase
	end
	// Reads end a load or extract; writes end a replace or store
	assign last_access = mem_ready_in & ((state_reg == ST_WRITE) | ((state_reg == ST_READ) &
		(op_reg != replace_memory_byte) & (op_reg != store_low_byte)));

	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			done_reg <= 1'b0;
		end else if (enable_in) begin
			// One-cycle pulse; a low clock enable stretches it
			done_reg <= (go & reg_only) | last_access;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Strobes stand until the memory answers ready
	assign mem_read_out = (state_reg == ST_READ);
	assign mem_write_out = (state_reg == ST_WRITE);
	assign mem_addr_out = addr_reg;
	assign mem_wdata_out = wdata_reg;
	assign acc_out = acc_reg;
	assign cond_out = cond_reg;
	assign overflow_out = overflow_reg;
	assign busy_out = (state_reg != ST_IDLE);
	assign done_out = done_reg;

endmodule

// File: byte_dp_checker.sv
`timescale 1ns/10ps
`include "byte_dp_cfg.svh"
module byte_dp_checker
	import byte_dp_pkg::*;
(
	// Clock, reset and request
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic enable_in,
	input wire logic start_in,
	input wire byte_op_t op_in,
	input wire logic [7:0] operand_in,
	input wire logic final_index_in,
	input wire logic [23:0] named_index_in,
	input wire logic [23:0] replace_index_in,
	// Memory port
	input wire logic mem_read_out,
	input wire logic mem_write_out,
	input wire logic [23:0] mem_addr_out,
	input wire logic mem_ready_in,
	// Results
	input wire logic [23:0] acc_out,
	input wire logic [2:0] cond_out,
	input wire logic overflow_out,
	input wire logic busy_out,
	input wire logic done_out
);
	// ----------
	// Properties
	// ----------
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	wire take = enable_in & start_in & !busy_out;
	wire [23:0] rsel = final_index_in ? named_index_in | replace_index_in : replace_index_in;
	neg_byte_a: assert property (
		take && op_in == negate_byte |=> done_out
		&& acc_out == {$past(acc_out[23:8]), 8'h0 - $past(acc_out[7:0])})
		else $error("negate result wrong");
	zero_ext_a: assert property (
		take && op_in == zero_extend_byte |=> acc_out == {16'h0000, $past(acc_out[7:0])}
		&& $stable(cond_out)) else $error("zero extend wrong");
	sign_ext_a: assert property (
		take && op_in == sign_extend_byte
		|=> acc_out == {{16{$past(acc_out[7])}}, $past(acc_out[7:0])})
		else $error("sign extend wrong");
	or_byte_a: assert property (
		take && op_in == or_operand_into_byte |=> acc_out[7:0] == ($past(acc_out[7:0])
		| $past(operand_in)) && $stable(acc_out[23:8])) else $error("or result wrong");
	cmp_flags_a: assert property (
		take && op_in == unsigned_compare_operand |=> $stable(acc_out) && cond_out ==
		(acc_out[7:0] < $past(operand_in) ? `CC_NEG : acc_out[7:0] == $past(operand_in)
		? `CC_ZERO : `CC_POS)) else $error("compare flags wrong");
	load_opnd_a: assert property (
		take && op_in == load_operand_to_byte |=> acc_out[7:0] == $past(operand_in)
		&& cond_out == (acc_out[7] ? `CC_NEG : acc_out[7:0] == 8'h00 ? `CC_ZERO : `CC_POS))
		else $error("load operand wrong");
	ovf_set_a: assert property (
		take && (op_in == negate_byte || op_in == absolute_byte) && acc_out[7:0] == 8'h80
		|=> overflow_out) else $error("overflow missing");
	read_hold_a: assert property (
		mem_read_out && !mem_ready_in |=> mem_read_out && $stable(mem_addr_out))
		else $error("read dropped early");
	no_write_a: assert property (
		take && op_in == replace_memory_byte && rsel[23:22] == 2'h0
		|=> done_out && !mem_write_out) else $error("replace 00 accessed memory");
	write_done_a: assert property (
		mem_write_out && mem_ready_in |=> done_out && !mem_write_out)
		else $error("write not completed");
	busy_mem_a: assert property (
		busy_out == (mem_read_out || mem_write_out)) else $error("busy without access");
	cover property (take && op_in == replace_memory_byte);
	cover property (mem_read_out && !mem_ready_in);
	cover property ($rose(overflow_out));
endmodule

// File: mem_model.sv
`timescale 1ns/10ps
module mem_model (
	// Request from the datapath
	input wire logic clock_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [23:0] addr_in,
	input wire logic [23:0] wdata_in,
	input wire logic slow_in,
	// Answer
	output logic ready_out,
	output logic [23:0] rdata_out
);
	logic [23:0] mem_reg [16];
	logic [23:0] last_reg = 24'h000000;
	logic wait_reg = 1'b0;
	initial for (int i = 0; i < 16; i++) mem_reg[i] = 24'(i) * 24'h0F1E2D + 24'h806040;
	assign ready_out = (rd_in | wr_in) & (!slow_in | wait_reg);
	// Idle bus shows the inverse of the last word, so stale data never matches
	assign rdata_out = rd_in & ready_out ? mem_reg[addr_in[3:0]] : ~last_reg;
	always @(posedge clock_in) begin
		wait_reg <= (rd_in | wr_in) & !ready_out;
		if (rd_in & ready_out) last_reg <= rdata_out;
		if (wr_in & ready_out) mem_reg[addr_in[3:0]] <= wdata_in;
	end
endmodule

// File: test_byte_processing_datapath.sv
`timescale 1ns/10ps
`include "byte_dp_cfg.svh"
module test_byte_processing_datapath import byte_dp_pkg::*;;
	logic clock_in = 0, reset_in = 1, start_in = 0, fi = 0, acc_load = 0, slow = 0, en = 1;
	byte_op_t op = OP_NONE;
	logic [7:0] opnd = 8'h00;
	logic [23:0] ea = 24'h0, ni = 24'h0, xi = 24'h0, ri = 24'h0, acc_d = 24'h0;
	logic [5:0] rsel = 6'h00;
	logic [23:0] gr [`NUM_GREGS];
	logic rd, wr, rdy, busy, done, ovf;
	logic [23:0] addr, wdata, rdata, acc;
	logic [2:0] cond;
	logic [27:0] rq [$];
	logic [23:0] wq [$];
	logic [23:0] aq [$];
	logic [23:0] mm [16];
	logic [23:0] m_acc;
	logic [2:0] m_cc;
	logic m_ov = 0;
	int fail_count = 0, compares = 0, cyc = 0;
	always #50 clock_in = ~clock_in;
	byte_processing_datapath byte_processing_datapath_i (.clock_in(clock_in),
		.reset_in(reset_in), .enable_in(en), .start_in(start_in), .op_in(op),
		.operand_in(opnd), .effective_address_in(ea), .final_index_in(fi),
		.named_index_in(ni), .extract_index_in(xi), .replace_index_in(ri),
		.source_register_select_in(rsel), .gregs_in(gr), .acc_load_in(acc_load),
		.acc_data_in(acc_d), .mem_read_out(rd), .mem_write_out(wr), .mem_addr_out(addr),
		.mem_wdata_out(wdata), .mem_ready_in(rdy), .mem_rdata_in(rdata), .acc_out(acc),
		.cond_out(cond), .overflow_out(ovf), .busy_out(busy), .done_out(done));
	mem_model mem_model_i (.clock_in(clock_in), .rd_in(rd), .wr_in(wr), .addr_in(addr),
		.wdata_in(wdata), .slow_in(slow), .ready_out(rdy), .rdata_out(rdata));
	// -----------------
	// Checks and report
	// -----------------
	task automatic chk(input logic [27:0] got, input logic [27:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	function automatic logic [2:0] flag(input logic [7:0] x);
		return x[7] ? `CC_NEG : x == 8'h00 ? `CC_ZERO : `CC_POS;
	endfunction
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (done) chk({ovf, cond, acc}, rq.size() ? rq.pop_front() : ~{ovf, cond, acc});
		if (wr && rdy) chk({4'h0, wdata}, {4'h0, wq.size() ? wq.pop_front() : ~wdata});
		if ((rd || wr) && rdy)
			chk({4'h0, addr}, {4'h0, aq.size() ? aq.pop_front() : ~addr});
		if (cyc == 10000) begin
			fail_count++;
			complete_run();
		end
	end
	// -------
	// Driving
	// -------
	task automatic do_op(input byte_op_t o, input logic [23:0] a);
		logic [23:0] w, ix;
		logic [7:0] b, v;
		logic [1:0] s;
		int k;
		@(posedge clock_in);
		acc_load <= 1'b1;
		acc_d <= a;
		opnd <= 8'($urandom);
		ea <= 24'($urandom);
		ni <= 24'($urandom);
		xi <= 24'($urandom);
		ri <= 24'($urandom);
		fi <= 1'($urandom);
		rsel <= 6'($urandom);
		slow <= 1'($urandom);
		foreach (gr[j]) gr[j] <= 24'($urandom);
		@(posedge clock_in);
		acc_load <= 1'b0;
		start_in <= 1'b1;
		op <= o;
		m_acc = a;
		b = a[7:0];
		ix = fi ? ni : 24'h0;
		case (o)
			extract_memory_byte: begin
				w = mm[4'(ea + ix + xi)];
				s = xi[23:22];
				aq.push_back(ea + ix + xi);
				b = s == 2'h0 ? w[7:0] : w[8 * (3 - s) +: 8];
			end
			sign_extend_byte: m_acc = {{16{b[7]}}, b};
			zero_extend_byte: m_acc = {16'h0000, b};
			unsigned_compare_operand: m_cc = b < opnd ? `CC_NEG : b == opnd ? `CC_ZERO : `CC_POS;
			negate_byte, absolute_byte: begin
				m_ov |= b == 8'h80;
				if (o == negate_byte || b[7]) b = 8'h00 - b;
			end
			or_operand_into_byte: b |= opnd;
			replace_memory_byte, store_low_byte: begin
				ix = o == store_low_byte ? 24'h0 : fi ? ni | ri : ri;
				s = o == store_low_byte ? 2'h3 : ix[23:22];
				k = 4'(ea + ix);
				w = mm[k];
				if (s != 2'h0) w[8 * (3 - s) +: 8] = b;
				if (s != 2'h0) wq.push_back(w);
				if (s != 2'h0) repeat (2) aq.push_back(ea + ix);
				mm[k] = w;
			end
			query_byte_bits: m_cc = flag(b & opnd);
			subtract_operand_from_byte: begin
				v = b - opnd;
				m_ov |= (b[7] != opnd[7]) && (v[7] != b[7]);
				b = v;
			end
			register_to_low_byte: for (int j = 0; j < `NUM_GREGS; j++) if (j == 0) b = 8'h00; else if (rsel[j - 1]) b |= gr[j - 1][7:0];
			load_operand_to_byte: b = opnd;
			load_memory_low_byte: begin
				b = mm[4'(ea)][7:0];
				aq.push_back(ea);
			end
			xor_operand_with_byte: b ^= opnd;
			default: ;
		endcase
		if (o == register_to_low_byte && rsel[5]) b |= gr[5][7:0];
		if (o != sign_extend_byte && o != zero_extend_byte) m_acc[7:0] = b;
		if (!(o inside {zero_extend_byte, unsigned_compare_operand, replace_memory_byte,
			query_byte_bits, store_low_byte, register_to_low_byte})) m_cc = flag(b);
		rq.push_back({m_ov, m_cc, m_acc});
		@(posedge clock_in);
		start_in <= 1'b0;
		for (k = 0; k < 20 && done !== 1'b1; k++) @(negedge clock_in);
	endtask
	initial begin
		for (int i = 0; i < 16; i++) mm[i] = 24'(i) * 24'h0F1E2D + 24'h806040;
		foreach (gr[i]) gr[i] = 24'h0;
		m_cc = `CC_RESET;
		void'($urandom(37));
		repeat (12) @(posedge clock_in);
		reset_in <= 1'b0;
		chk({ovf, cond, acc}, {1'b0, `CC_RESET, `ACC_RESET});
		repeat (300) do_op(byte_op_t'(1 + $urandom % 15), 24'($urandom));
		do_op(negate_byte, 24'h123480);
		do_op(absolute_byte, 24'hABCD80);
		// Clock enable low: both a request and a load must be ignored
		@(posedge clock_in);
		en <= 1'b0;
		start_in <= 1'b1;
		acc_load <= 1'b1;
		acc_d <= 24'h5A5A5A;
		op <= xor_operand_with_byte;
		opnd <= 8'h3C;
		repeat (3) @(posedge clock_in);
		en <= 1'b1;
		start_in <= 1'b0;
		acc_load <= 1'b0;
		@(posedge clock_in);
		chk({ovf, cond, acc}, {m_ov, m_cc, m_acc});
		// Mid-run reset clears the sticky overflow
		reset_in <= 1'b1;
		@(posedge clock_in);
		reset_in <= 1'b0;
		chk({ovf, cond, acc}, {1'b0, `CC_RESET, `ACC_RESET});
		m_ov = 1'b0;
		m_cc = `CC_RESET;
		do_op(negate_byte, 24'h000080);
		repeat (3) @(posedge clock_in);
		chk(28'(rq.size() + wq.size() + aq.size()), 28'h0000000);
		complete_run();
	end
endmodule
bind byte_processing_datapath byte_dp_checker byte_dp_checker_i (.clock_in(clock_in),
	.reset_in(reset_in), .enable_in(enable_in), .start_in(start_in), .op_in(op_in),
	.operand_in(operand_in),
	.final_index_in(final_index_in), .named_index_in(named_index_in),
	.replace_index_in(replace_index_in), .mem_read_out(mem_read_out),
	.mem_write_out(mem_write_out), .mem_addr_out(mem_addr_out), .mem_ready_in(mem_ready_in),
	.acc_out(acc_out), .cond_out(cond_out), .overflow_out(overflow_out),
	.busy_out(busy_out), .done_out(done_out));
